//--- deframer_regs_consts.svh
// register offsets, field positions, reset values and codes of the setup registers
`ifndef DEFRAMER_REGS_CONSTS_SVH
`define DEFRAMER_REGS_CONSTS_SVH

`define CHAN_MASK_ADDR   12'h008
`define LANE_MODE_ADDR   12'h110
`define OSC_CTRL_ADDR    12'h130
`define GAIN_LO_ADDR     12'h146
`define GAIN_HI_ADDR     12'h147
`define LINK_PAGE_ADDR   12'h300
`define LANE_SCR_ADDR    12'h453
`define FRAMING_ADDR     12'h458
`define DEF_RESET_ADDR   12'h475

`define LINK_EN_MSB      1
`define PAGE_SEL_BIT     2
`define TOPOLOGY_BIT     3
`define SCR_BIT          7
`define LANE_CNT_MSB     4
`define SUBCLASS_MSB     7
`define SUBCLASS_LSB     5
`define NP_MSB           4
`define DEF_HOLD_BIT     3
`define OSC_EN_BIT       6
`define MOD_EN_BIT       2
`define SIDEBAND_BIT     1
`define MODE_DUAL_BIT    5
`define MODE_MSB         5
`define CHAN_MASK_MSB    5
`define CH0_MASK_BIT     0
`define CH1_MASK_BIT     3
`define GAIN_HI_MSB      3

`define DEF_RESET_CODE   8'h09
`define DEF_RELEASE_CODE 8'h01
`define GAIN_UNITY_SHIFT 11
`define GAIN_UNITY       12'h800
`define SAMPLE_MAX       16'h7FFF
`define SAMPLE_MIN       16'h8000

`define DEF_RESET_RST    8'h09
`define CFG_RST          8'h00
`define MODE_RST         6'h00
`define MASK_RST         6'h00

`endif

//--- deframer_regs_pkg.sv
// types shared by the setup register block
`default_nettype none
package deframer_regs_pkg;
    typedef logic [11:0]        reg_addr_t;
    typedef logic [7:0]         reg_data_t;
    typedef logic [11:0]        gain_t;
    typedef logic signed [15:0] sample_t;
    typedef enum logic
    {
        SB_UPPER = 1'b0,
        SB_LOWER = 1'b1
    } sideband_t;
endpackage : deframer_regs_pkg
`default_nettype wire

//--- link_cfg_bank.sv
// per-link deframer setup registers: scrambling, framing, soft reset
`default_nettype none
`include "deframer_regs_consts.svh"
module link_cfg_bank
(
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    input  wire logic                        wr_en,
    input  wire deframer_regs_pkg::reg_addr_t reg_addr,
    input  wire deframer_regs_pkg::reg_data_t reg_wdata,
    output var  deframer_regs_pkg::reg_data_t scr_cfg_r,
    output var  deframer_regs_pkg::reg_data_t framing_cfg_r,
    output var  deframer_regs_pkg::reg_data_t reset_cfg_r
);
    import deframer_regs_pkg::*;

    reg_data_t scr_cfg_nxt;
    reg_data_t framing_cfg_nxt;
    reg_data_t reset_cfg_nxt;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        scr_cfg_nxt     = scr_cfg_r;
        framing_cfg_nxt = framing_cfg_r;
        reset_cfg_nxt   = reset_cfg_r;
        if (wr_en)
        begin
            if (reg_addr == `LANE_SCR_ADDR)
                scr_cfg_nxt = reg_wdata;
            else if (reg_addr == `FRAMING_ADDR)
                framing_cfg_nxt = reg_wdata;
            else if (reg_addr == `DEF_RESET_ADDR)
                reset_cfg_nxt = reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            scr_cfg_r     <= `CFG_RST;
            framing_cfg_r <= `CFG_RST;
            reset_cfg_r   <= `DEF_RESET_RST;
        end
        else
        begin
            scr_cfg_r     <= scr_cfg_nxt;
            framing_cfg_r <= framing_cfg_nxt;
            reset_cfg_r   <= reset_cfg_nxt;
        end
    end
endmodule : link_cfg_bank
`default_nettype wire

//--- chan_gain_scale.sv
// per-channel digital gain with sideband selection on complex samples
`default_nettype none
`include "deframer_regs_consts.svh"
module chan_gain_scale
(
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    input  wire deframer_regs_pkg::gain_t     gain_word,
    input  wire deframer_regs_pkg::sideband_t sideband,
    input  wire deframer_regs_pkg::sample_t   i_in,
    input  wire deframer_regs_pkg::sample_t   q_in,
    output var  deframer_regs_pkg::sample_t   i_out_r,
    output var  deframer_regs_pkg::sample_t   q_out_r
);
    import deframer_regs_pkg::*;

    logic signed [16:0] i_ext;
    logic signed [16:0] q_ext;
    logic signed [12:0] g_ext;
    logic signed [29:0] prod_i;
    logic signed [29:0] prod_q;
    sample_t            i_out_nxt;
    sample_t            q_out_nxt;

    function automatic sample_t sat_scale(input logic signed [29:0] p);
        logic signed [29:0] s;
        s = p >>> `GAIN_UNITY_SHIFT;
        if (s > $signed({14'h0, `SAMPLE_MAX}))
            return `SAMPLE_MAX;
        else if (s < $signed({14'h3FFF, `SAMPLE_MIN}))
            return `SAMPLE_MIN;
        else
            return s[15:0];
    endfunction : sat_scale

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        i_ext = {i_in[15], i_in};
        q_ext = {q_in[15], q_in};
        g_ext = {1'b0, gain_word};
        // lower sideband is the conjugate, i.e. spectral flip
        if (sideband == SB_LOWER)
            q_ext = -q_ext;
        prod_i    = i_ext * g_ext;
        prod_q    = q_ext * g_ext;
        i_out_nxt = sat_scale(prod_i);
        q_out_nxt = sat_scale(prod_q);
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            i_out_r <= '0;
            q_out_r <= '0;
        end
        else
        begin
            i_out_r <= i_out_nxt;
            q_out_r <= q_out_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_unity_gain;
        @(posedge core_clk) disable iff (!rstn)
        (gain_word == `GAIN_UNITY) |=> (i_out_r == $past(i_in));
    endproperty
    a_unity_gain: assert property (p_unity_gain)
        else $error("unity gain does not pass the sample");

    property p_upper_sideband;
        @(posedge core_clk) disable iff (!rstn)
        (gain_word == `GAIN_UNITY && sideband == SB_UPPER) |=> (q_out_r == $past(q_in));
    endproperty
    a_upper_sideband: assert property (p_upper_sideband)
        else $error("upper sideband altered quadrature");

    property p_lower_sideband;
        @(posedge core_clk) disable iff (!rstn)
        (gain_word == `GAIN_UNITY && sideband == SB_LOWER && q_in != `SAMPLE_MIN)
        |=> (q_out_r == -$past(q_in));
    endproperty
    a_lower_sideband: assert property (p_lower_sideband)
        else $error("lower sideband did not invert quadrature");
endmodule : chan_gain_scale
`default_nettype wire

//--- deframer_setup_regs.sv
// deframer and channel datapath setup registers with host register port
//
// Contract
// - writing release code 0x01 to the reset register takes deframer out
// - paging bit 2 picks link 0 or link 1 for deframer accesses
// - lane register bit 7 turns descrambling on or off
// - six-bit mask picks channels for writes; bit 0 ch0, bit 3 ch1
// - 12-bit gain split: low byte, then bits 11..8 in next register
// - gain code 2048 is unity; output is sample times code over 2048
// - oscillator control bit 6 enables the masked channels' oscillator
// - oscillator control bit 2 enables modulus accumulation
// - sideband bit 1 clear selects the upper sideband
// - sideband bit 1 selects lower sideband, spectrally inverted
// - mode bit 5 selects dual link; bits 5..0 pick lane mode
//
// The address-and-strobe port was decided locally.
`default_nettype none
`include "deframer_regs_consts.svh"
module deframer_setup_regs
(
    input  wire logic                              core_clk,
    input  wire logic                              rstn,
    input  wire deframer_regs_pkg::reg_addr_t       reg_addr,
    input  wire deframer_regs_pkg::reg_data_t       reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output var  deframer_regs_pkg::reg_data_t       reg_rdata,
    input  wire deframer_regs_pkg::sample_t [1:0]   chan_i_in,
    input  wire deframer_regs_pkg::sample_t [1:0]   chan_q_in,
    output var  deframer_regs_pkg::sample_t [1:0]   chan_i_out,
    output var  deframer_regs_pkg::sample_t [1:0]   chan_q_out,
    output var  logic [5:0]                        serial_lane_mode_select,
    output var  logic                              dual_link_mode,
    output var  logic [1:0]                        link_enable,
    output var  logic                              link_topology_dual,
    output var  logic                              link_page_sel,
    output var  logic [1:0]                        descramble_enable,
    output var  logic [1:0][4:0]                   lane_count_m1,
    output var  logic [1:0][2:0]                   subclass_version_field,
    output var  logic [1:0][4:0]                   sample_bits_m1,
    output var  logic [1:0]                        lane_deframer_reset,
    output var  logic [1:0]                        channel_oscillator_enable,
    output var  logic [1:0]                        modulus_enable,
    output var  logic [1:0]                        sideband_lower,
    output var  deframer_regs_pkg::gain_t [1:0]     channel_gain_word
);
    import deframer_regs_pkg::*;

    localparam int MASK_BIT [2] = '{`CH0_MASK_BIT, `CH1_MASK_BIT};

    logic [5:0]        mode_r;
    logic [5:0]        mode_nxt;
    logic [5:0]        chan_mask_r;
    logic [5:0]        chan_mask_nxt;
    reg_data_t         paging_r;
    reg_data_t         paging_nxt;
    reg_data_t         rdata_r;
    reg_data_t         rdata_nxt;
    reg_data_t [1:0]   osc_ctrl_r;
    reg_data_t [1:0]   osc_ctrl_nxt;
    gain_t [1:0]       gain_r;
    gain_t [1:0]       gain_nxt;
    reg_data_t [1:0]   scr_cfg;
    reg_data_t [1:0]   framing_cfg;
    reg_data_t [1:0]   reset_cfg;
    logic [1:0]        link_wr;
    logic [1:0]        chan_sel;
    logic              rd_chan;

    ////////////////////////////////////////////////////////////////////////
    // global registers: mode, channel mask, link paging
    always_comb
    begin
        mode_nxt      = mode_r;
        chan_mask_nxt = chan_mask_r;
        paging_nxt    = paging_r;
        if (reg_wr)
        begin
            if (reg_addr == `LANE_MODE_ADDR)
                mode_nxt = reg_wdata[`MODE_MSB:0];
            else if (reg_addr == `CHAN_MASK_ADDR)
                chan_mask_nxt = reg_wdata[`CHAN_MASK_MSB:0];
            else if (reg_addr == `LINK_PAGE_ADDR)
                paging_nxt = reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_r      <= `MODE_RST;
            chan_mask_r <= `MASK_RST;
            paging_r    <= `CFG_RST;
        end
        else
        begin
            mode_r      <= mode_nxt;
            chan_mask_r <= chan_mask_nxt;
            paging_r    <= paging_nxt;
        end
    end

    assign serial_lane_mode_select = mode_r;
    assign dual_link_mode          = mode_r[`MODE_DUAL_BIT];
    assign link_enable             = paging_r[`LINK_EN_MSB:0];
    assign link_topology_dual      = paging_r[`TOPOLOGY_BIT];
    assign link_page_sel           = paging_r[`PAGE_SEL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // per-link deframer registers, written only on the paged link
    genvar gl;
    generate
        for (gl = 0; gl < 2; gl++)
        begin : g_link
            assign link_wr[gl] = reg_wr && (paging_r[`PAGE_SEL_BIT] == 1'(gl));

            link_cfg_bank u_bank
            (
                .core_clk      (core_clk),
                .rstn          (rstn),
                .wr_en         (link_wr[gl]),
                .reg_addr      (reg_addr),
                .reg_wdata     (reg_wdata),
                .scr_cfg_r     (scr_cfg[gl]),
                .framing_cfg_r (framing_cfg[gl]),
                .reset_cfg_r   (reset_cfg[gl])
            );

            assign descramble_enable[gl]      = scr_cfg[gl][`SCR_BIT];
            assign lane_count_m1[gl]          = scr_cfg[gl][`LANE_CNT_MSB:0];
            assign subclass_version_field[gl] =
                framing_cfg[gl][`SUBCLASS_MSB:`SUBCLASS_LSB];
            assign sample_bits_m1[gl]         = framing_cfg[gl][`NP_MSB:0];
            assign lane_deframer_reset[gl]    = reset_cfg[gl][`DEF_HOLD_BIT];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // per-channel registers, written on every channel set in the mask
    always_comb
    begin
        osc_ctrl_nxt = osc_ctrl_r;
        gain_nxt     = gain_r;
        for (int c = 0; c < 2; c++)
        begin
            chan_sel[c] = chan_mask_r[MASK_BIT[c]];
            if (reg_wr && chan_sel[c])
            begin
                if (reg_addr == `OSC_CTRL_ADDR)
                    osc_ctrl_nxt[c] = reg_wdata;
                else if (reg_addr == `GAIN_LO_ADDR)
                    gain_nxt[c][7:0] = reg_wdata;
                else if (reg_addr == `GAIN_HI_ADDR)
                    gain_nxt[c][11:8] = reg_wdata[`GAIN_HI_MSB:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_ctrl_r <= '0;
            gain_r     <= {2{`GAIN_UNITY}};
        end
        else
        begin
            osc_ctrl_r <= osc_ctrl_nxt;
            gain_r     <= gain_nxt;
        end
    end

    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++)
        begin : g_chan
            assign channel_oscillator_enable[gc] = osc_ctrl_r[gc][`OSC_EN_BIT];
            assign modulus_enable[gc]            = osc_ctrl_r[gc][`MOD_EN_BIT];
            assign sideband_lower[gc]            = osc_ctrl_r[gc][`SIDEBAND_BIT];
            assign channel_gain_word[gc]         = gain_r[gc];

            chan_gain_scale u_scale
            (
                .core_clk  (core_clk),
                .rstn      (rstn),
                .gain_word (gain_r[gc]),
                .sideband  (sideband_t'(osc_ctrl_r[gc][`SIDEBAND_BIT])),
                .i_in      (chan_i_in[gc]),
                .q_in      (chan_q_in[gc]),
                .i_out_r   (chan_i_out[gc]),
                .q_out_r   (chan_q_out[gc])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // read port: paged link, lowest masked channel (ch0 if none masked); unmapped reads zero
    always_comb
    begin
        rd_chan   = !chan_mask_r[`CH0_MASK_BIT] && chan_mask_r[`CH1_MASK_BIT];
        rdata_nxt = '0;
        if (reg_rd)
        begin
            if (reg_addr == `LANE_MODE_ADDR)
                rdata_nxt = {2'b00, mode_r};
            else if (reg_addr == `CHAN_MASK_ADDR)
                rdata_nxt = {2'b00, chan_mask_r};
            else if (reg_addr == `LINK_PAGE_ADDR)
                rdata_nxt = paging_r;
            else if (reg_addr == `LANE_SCR_ADDR)
                rdata_nxt = scr_cfg[paging_r[`PAGE_SEL_BIT]];
            else if (reg_addr == `FRAMING_ADDR)
                rdata_nxt = framing_cfg[paging_r[`PAGE_SEL_BIT]];
            else if (reg_addr == `DEF_RESET_ADDR)
                rdata_nxt = reset_cfg[paging_r[`PAGE_SEL_BIT]];
            else if (reg_addr == `OSC_CTRL_ADDR)
                rdata_nxt = osc_ctrl_r[rd_chan];
            else if (reg_addr == `GAIN_LO_ADDR)
                rdata_nxt = gain_r[rd_chan][7:0];
            else if (reg_addr == `GAIN_HI_ADDR)
                rdata_nxt = {4'h0, gain_r[rd_chan][11:8]};
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_r <= '0;
        else
            rdata_r <= rdata_nxt;
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    sequence s_wr(logic [11:0] a);
        reg_wr && reg_addr == a;
    endsequence

    property p_scr_paged;
        @(posedge core_clk) disable iff (!rstn)
        s_wr(`LANE_SCR_ADDR) ##0 !paging_r[`PAGE_SEL_BIT]
        |=> descramble_enable[0] == $past(reg_wdata[`SCR_BIT])
            && $stable(descramble_enable[1]);
    endproperty
    a_scr_paged: assert property (p_scr_paged)
        else $error("scramble write missed link 0 or leaked to link 1");

    property p_enter_reset;
        @(posedge core_clk) disable iff (!rstn)
        s_wr(`DEF_RESET_ADDR) ##0 reg_wdata == `DEF_RESET_CODE ##0 paging_r[`PAGE_SEL_BIT]
        |=> lane_deframer_reset[1];
    endproperty
    a_enter_reset: assert property (p_enter_reset)
        else $error("reset code did not hold link 1 deframer");

    property p_release;
        @(posedge core_clk) disable iff (!rstn)
        s_wr(`DEF_RESET_ADDR) ##0 reg_wdata == `DEF_RELEASE_CODE ##0 !paging_r[`PAGE_SEL_BIT]
        |=> !lane_deframer_reset[0] ##1 !lane_deframer_reset[0] || $past(reg_wr);
    endproperty
    a_release: assert property (p_release)
        else $error("release code did not free link 0 deframer");

    property p_gain_low;
        @(posedge core_clk) disable iff (!rstn)
        s_wr(`GAIN_LO_ADDR) ##0 chan_mask_r[`CH0_MASK_BIT]
        |=> channel_gain_word[0][7:0] == $past(reg_wdata);
    endproperty
    a_gain_low: assert property (p_gain_low)
        else $error("gain low byte not taken by channel 0");

    property p_gain_high;
        @(posedge core_clk) disable iff (!rstn)
        s_wr(`GAIN_HI_ADDR) ##0 chan_mask_r[`CH1_MASK_BIT]
        |=> channel_gain_word[1][11:8] == $past(reg_wdata[3:0]) && $stable(gain_r[1][7:0]);
    endproperty
    a_gain_high: assert property (p_gain_high)
        else $error("gain high bits not taken by channel 1");

    property p_osc_enable;
        @(posedge core_clk) disable iff (!rstn)
        s_wr(`OSC_CTRL_ADDR) ##0 chan_mask_r[`CH1_MASK_BIT]
        |=> channel_oscillator_enable[1] == $past(reg_wdata[`OSC_EN_BIT])
            && modulus_enable[1] == $past(reg_wdata[`MOD_EN_BIT]);
    endproperty
    a_osc_enable: assert property (p_osc_enable)
        else $error("oscillator control not applied to channel 1");

    property p_unpaged_chan;
        @(posedge core_clk) disable iff (!rstn)
        s_wr(`OSC_CTRL_ADDR) ##0 !chan_mask_r[`CH0_MASK_BIT]
        |=> $stable(osc_ctrl_r[0]);
    endproperty
    a_unpaged_chan: assert property (p_unpaged_chan)
        else $error("unmasked channel took a write");

    property p_mode_dual;
        @(posedge core_clk) disable iff (!rstn)
        s_wr(`LANE_MODE_ADDR) |=> dual_link_mode == $past(reg_wdata[`MODE_DUAL_BIT]);
    endproperty
    a_mode_dual: assert property (p_mode_dual)
        else $error("mode bit 5 not reflected as dual link");

    property p_read_once;
        @(posedge core_clk) disable iff (!rstn)
        (reg_rd && reg_addr == `LINK_PAGE_ADDR) ##1 !reg_rd
        |-> reg_rdata == $past(paging_r) ##1 reg_rdata == '0;
    endproperty
    a_read_once: assert property (p_read_once)
        else $error("paging read data wrong or held too long");
endmodule : deframer_setup_regs
`default_nettype wire

//--- cfg_host.sv
// host model driving the setup register port
`default_nettype none
module cfg_host
(
    input  wire logic                         core_clk,
    input  wire deframer_regs_pkg::reg_data_t reg_rdata,
    output var  deframer_regs_pkg::reg_addr_t reg_addr,
    output var  deframer_regs_pkg::reg_data_t reg_wdata,
    output var  logic                         reg_wr,
    output var  logic                         reg_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    import deframer_regs_pkg::*;

    initial
    begin
        reg_addr  = 12'h000;
        reg_wdata = 8'h00;
        reg_wr    = 1'h0;
        reg_rd    = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic write_reg(input reg_addr_t a, input reg_data_t d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask : write_reg

    // d: data in the cycle after the strobe, z: the cycle after that
    task automatic read_reg(input reg_addr_t a, output reg_data_t d, output reg_data_t z);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
        @(posedge core_clk);
        #1 z = reg_rdata;
    endtask : read_reg

    // one deframer pass, links kept disabled
    task automatic link_setup(input logic lnk, input logic dual, input reg_data_t lane,
                              input reg_data_t frm);
        write_reg(12'h300, {4'h0, dual, lnk, 2'h0});
        write_reg(12'h475, 8'h09);
        write_reg(12'h453, lane);
        write_reg(12'h458, frm);
        write_reg(12'h475, 8'h01);
    endtask : link_setup
endmodule : cfg_host
`default_nettype wire

//--- deframer_setup_regs_bench.sv
// self-checking bench of the deframer and channel setup registers
`default_nettype none
module deframer_setup_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import deframer_regs_pkg::*;

    typedef struct {reg_addr_t a; reg_data_t w; reg_data_t r;} row_t;

    logic core_clk = 1'h0;
    logic rstn;
    reg_addr_t reg_addr;
    reg_data_t reg_wdata, reg_rdata, rd, rz;
    logic reg_wr, reg_rd;
    sample_t [1:0] chan_i_in, chan_q_in, chan_i_out, chan_q_out;
    logic [5:0] serial_lane_mode_select;
    logic dual_link_mode, link_topology_dual, link_page_sel;
    logic [1:0] link_enable, descramble_enable, lane_deframer_reset;
    logic [1:0] channel_oscillator_enable, modulus_enable, sideband_lower;
    logic [1:0][4:0] lane_count_m1, sample_bits_m1;
    logic [1:0][2:0] subclass_version_field;
    gain_t [1:0] channel_gain_word;
    logic [5:0] osc_bits;
    int failures = 0;
    int checked = 0;
    row_t rows[7] = '{'{12'h110, 8'hE5, 8'h25}, '{12'h008, 8'hC9, 8'h09},
                      '{12'h147, 8'hFA, 8'h0A}, '{12'h146, 8'h34, 8'h34},
                      '{12'h130, 8'h46, 8'h46}, '{12'h300, 8'h0C, 8'h0C},
                      '{12'h123, 8'h55, 8'h00}};

    always #2.5 core_clk = ~core_clk;

    assign osc_bits = {channel_oscillator_enable, modulus_enable, sideband_lower};

    deframer_setup_regs DUT (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .chan_i_in(chan_i_in), .chan_q_in(chan_q_in), .chan_i_out(chan_i_out),
        .chan_q_out(chan_q_out), .serial_lane_mode_select(serial_lane_mode_select),
        .dual_link_mode(dual_link_mode), .link_enable(link_enable),
        .link_topology_dual(link_topology_dual), .link_page_sel(link_page_sel),
        .descramble_enable(descramble_enable), .lane_count_m1(lane_count_m1),
        .subclass_version_field(subclass_version_field), .sample_bits_m1(sample_bits_m1),
        .lane_deframer_reset(lane_deframer_reset),
        .channel_oscillator_enable(channel_oscillator_enable),
        .modulus_enable(modulus_enable), .sideband_lower(sideband_lower),
        .channel_gain_word(channel_gain_word));

    cfg_host host (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (failures == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    initial
    begin
        #100000;
        failures++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rstn = 1'h0;
        chan_i_in = {16'h7000, 16'h1000};
        chan_q_in = {16'h0800, 16'h0800};
        repeat (2) @(posedge core_clk);
        rstn <= 1'h1;
        #1;
        check("deframer held", lane_deframer_reset, 16'h3);
        check("unity gain", channel_gain_word[1], 16'h800);
        check("links off", link_enable, 16'h0);
        host.read_reg(12'h475, rd, rz);
        check("reset reg", rd, 16'h09);
        check("rdata after", rz, 16'h00);
        foreach (rows[k])
        begin
            host.write_reg(rows[k].a, rows[k].w);
            host.read_reg(rows[k].a, rd, rz);
            check("readback", rd, rows[k].r);
        end
        check("mode", {dual_link_mode, serial_lane_mode_select}, 16'h65);
        check("gain ch1", channel_gain_word[1], 16'hA34);
        check("osc", osc_bits, 16'h3F);
        check("topology", {link_topology_dual, link_page_sel}, 16'h3);
        host.link_setup(1'h0, 1'h1, 8'h87, 8'h2F);
        #1;
        check("one pass", lane_deframer_reset, 16'h2);
        host.link_setup(1'h1, 1'h1, 8'h03, 8'h0B);
        #1;
        check("scramble", descramble_enable, 16'h1);
        check("lanes", {lane_count_m1[1], lane_count_m1[0]}, 16'h067);
        check("subclass 1", subclass_version_field[1], 16'h0);
        check("subclass 0", subclass_version_field[0], 16'h1);
        check("np", {sample_bits_m1[1], sample_bits_m1[0]}, 16'h16F);
        check("released", lane_deframer_reset, 16'h0);
        host.write_reg(12'h300, 8'h0B);
        host.read_reg(12'h453, rd, rz);
        check("page 0", rd, 16'h87);
        check("links on", link_enable, 16'h3);
        host.write_reg(12'h008, 8'h01);
        host.write_reg(12'h146, 8'h00);
        host.write_reg(12'h147, 8'h04);
        repeat (2) @(posedge core_clk);
        #1;
        check("gain ch0", channel_gain_word[0], 16'h400);
        check("i0", chan_i_out[0], 16'h0800);
        check("q0 lower", chan_q_out[0], 16'hFC00);
        check("i1 sat", chan_i_out[1], 16'h7FFF);
        check("q1 lower", chan_q_out[1], 16'hF5CC);
        host.write_reg(12'h130, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        check("q0 upper", chan_q_out[0], 16'h0400);
        check("osc ch0 off", osc_bits, 16'h2A);
        host.write_reg(12'h008, 8'h08);
        host.read_reg(12'h130, rd, rz);
        check("ch1 osc", rd, 16'h46);
        host.write_reg(12'h130, 8'h42);
        host.write_reg(12'h147, 8'h08);
        host.write_reg(12'h146, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        check("osc ch1 only", osc_bits, 16'h22);
        check("i1 unity", chan_i_out[1], 16'h7000);
        check("q1 unity lower", chan_q_out[1], 16'hF800);
        @(posedge core_clk);
        rstn <= 1'h0;
        #1;
        check("reset state", {lane_deframer_reset, link_enable}, 16'hC);
        check("reset gain", channel_gain_word[1], 16'h800);
        @(posedge core_clk);
        rstn <= 1'h1;
        host.read_reg(12'h008, rd, rz);
        check("mask reset", rd, 16'h00);
        summarize();
    end
endmodule : deframer_setup_regs_bench
`default_nettype wire
